// ==== logic/ggr_register_bank.sv ====
`timescale 1ns/10ps
`default_nettype none
module ggr_register_bank #(
  parameter logic [30:0] SCAN_CYCLES = 31'(ggr_pkg::SCAN_CYCLES_DEF)
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic [7:0] regAddr,
  input wire logic regWrEn,
  input wire logic [7:0] regWrData,
  input wire logic regRdEn,
  output logic [7:0] regRdData,
  input wire logic alertResponseDone,
  input wire logic chargeTickUp,
  input wire logic chargeTickDown,
  input wire logic supplyDroop,
  output logic convStart,
  input wire logic voltDone,
  input wire logic [15:0] voltIn,
  input wire logic ampDone,
  input wire logic [15:0] ampIn,
  input wire logic tempDone,
  input wire logic [15:0] tempIn,
  output logic analogEnable,
  input wire logic alertPinIn,
  output logic alertPinOut,
  output logic alertPinOe
);
  import ggr_pkg::*;

  typedef struct packed {
    logic [7:0] status;
    logic [7:0] ctrl;
    logic [15:0] acc;
    logic [15:0] chgUp;
    logic [15:0] chgDn;
    logic [15:0] volt;
    logic [15:0] voltUp;
    logic [15:0] voltDn;
    logic [15:0] amp;
    logic [15:0] ampUp;
    logic [15:0] ampDn;
    logic [15:0] temp;
    logic [7:0] tempUp;
    logic [7:0] tempDn;
    logic [11:0] presc;
    logic [30:0] scanCnt;
    logic convBusy;
    logic singlePending;
    logic alertLatched;
    logic convStart;
    logic [7:0] rdData;
    logic [7:0] shadow;
    logic [7:0] shadowAddr;
  } ggr_state_t;

  ggr_state_t st;
  ggr_state_t next_st;
  logic [7:0] setBits;
  logic halt;
  logic loadReq;
  logic stepUp;
  logic stepDown;
  logic [15:0] accStep;
  logic [11:0] prescTop;
  ggr_mode_t mode;
  ggr_pin_t pinMode;

  assign mode = ggr_mode_t'(st.ctrl[CTRL_MODE_POS +: 2]);
  assign pinMode = ggr_pin_t'(st.ctrl[CTRL_PIN_POS +: 2]);
  assign halt = st.ctrl[CTRL_SHDN_POS] | supplyDroop;
  assign loadReq = (pinMode == PIN_CHG_DONE) & ~alertPinIn;
  assign prescTop = ggr_presc_top(st.ctrl[CTRL_PRESC_POS +: 3]);

  always_comb begin
    next_st = st;
    setBits = 8'h00;
    stepUp = 1'b0;
    stepDown = 1'b0;
    accStep = st.acc;
    next_st.convStart = 1'b0;

    // Prescaler: residual below one count is simply held, and dropped on halt
    if (halt) begin
      next_st.presc = 12'h000;
    end else if (chargeTickUp && !chargeTickDown) begin
      if (st.presc >= prescTop) begin
        next_st.presc = 12'h000;
        stepUp = 1'b1;
      end else begin
        next_st.presc = st.presc + 12'h001;
      end
    end else if (chargeTickDown && !chargeTickUp) begin
      if (st.presc == 12'h000) begin
        next_st.presc = prescTop;
        stepDown = 1'b1;
      end else begin
        next_st.presc = st.presc - 12'h001;
      end
    end

    if (stepUp) begin
      accStep = st.acc + 16'h0001;
      if (st.acc == 16'hffff) begin
        setBits[ST_WRAP] = 1'b1;
      end
    end else if (stepDown) begin
      accStep = st.acc - 16'h0001;
      if (st.acc == 16'h0000) begin
        setBits[ST_WRAP] = 1'b1;
      end
    end
    if (stepUp || stepDown) begin
      next_st.acc = accStep;
      if (accStep > st.chgUp) begin
        setBits[ST_CHG_HI] = 1'b1;
      end
      if (accStep < st.chgDn) begin
        setBits[ST_CHG_LO] = 1'b1;
      end
    end
    if (loadReq) begin
      next_st.acc = ACC_FULL;
    end

    // Results are compared only on their completion strobe
    if (voltDone) begin
      next_st.volt = voltIn;
      if (voltIn > st.voltUp || voltIn < st.voltDn) begin
        setBits[ST_VOLT] = 1'b1;
      end
    end
    if (ampDone) begin
      next_st.amp = ampIn;
      if (ampIn > st.ampUp || ampIn < st.ampDn) begin
        setBits[ST_AMP] = 1'b1;
      end
    end
    if (tempDone) begin
      next_st.temp = tempIn;
      if (tempIn[15:8] > st.tempUp || tempIn[15:8] < st.tempDn) begin
        setBits[ST_TEMP] = 1'b1;
      end
    end
    if (supplyDroop) begin
      setBits[ST_DROOP] = 1'b1;
    end

    // Conversion sequencing; a set ends with its temperature result
    if (tempDone) begin
      next_st.convBusy = 1'b0;
    end
    if (st.scanCnt != 31'd0) begin
      next_st.scanCnt = st.scanCnt - 31'd1;
    end
    if (!halt && !st.convBusy && !st.convStart) begin
      case (mode)
        MODE_CONT: begin
          next_st.convStart = 1'b1;
        end
        MODE_SCAN: begin
          if (st.scanCnt == 31'd0) begin
            next_st.convStart = 1'b1;
            next_st.scanCnt = SCAN_CYCLES - 31'd1;
          end
        end
        MODE_SINGLE: begin
          if (st.singlePending) begin
            next_st.convStart = 1'b1;
            next_st.singlePending = 1'b0;
          end
        end
        MODE_SLEEP: begin
          next_st.singlePending = 1'b0;
        end
        default: begin
          next_st.singlePending = 1'b0;
        end
      endcase
    end
    if (next_st.convStart) begin
      next_st.convBusy = 1'b1;
    end

    // Register reads; the status clear loses to a same-cycle event
    if (regRdEn) begin
      case (regAddr)
        ADDR_STATUS: next_st.rdData = st.status;
        ADDR_CTRL: next_st.rdData = st.ctrl;
        ADDR_ACC_HI: next_st.rdData = st.acc[15:8];
        ADDR_CHG_UP_HI: next_st.rdData = st.chgUp[15:8];
        ADDR_CHG_UP_LO: next_st.rdData = st.chgUp[7:0];
        ADDR_CHG_DN_HI: next_st.rdData = st.chgDn[15:8];
        ADDR_CHG_DN_LO: next_st.rdData = st.chgDn[7:0];
        ADDR_VOLT_HI: next_st.rdData = st.volt[15:8];
        ADDR_VUP_HI: next_st.rdData = st.voltUp[15:8];
        ADDR_VUP_LO: next_st.rdData = st.voltUp[7:0];
        ADDR_VDN_HI: next_st.rdData = st.voltDn[15:8];
        ADDR_VDN_LO: next_st.rdData = st.voltDn[7:0];
        ADDR_AMP_HI: next_st.rdData = st.amp[15:8];
        ADDR_AUP_HI: next_st.rdData = st.ampUp[15:8];
        ADDR_AUP_LO: next_st.rdData = st.ampUp[7:0];
        ADDR_ADN_HI: next_st.rdData = st.ampDn[15:8];
        ADDR_ADN_LO: next_st.rdData = st.ampDn[7:0];
        ADDR_TEMP_HI: next_st.rdData = st.temp[15:8];
        ADDR_TUP: next_st.rdData = st.tempUp;
        ADDR_TDN: next_st.rdData = st.tempDn;
        ADDR_ACC_LO, ADDR_VOLT_LO, ADDR_AMP_LO, ADDR_TEMP_LO: begin
          if (st.shadowAddr == regAddr) begin
            next_st.rdData = st.shadow;
          end else begin
            case (regAddr)
              ADDR_ACC_LO: next_st.rdData = st.acc[7:0];
              ADDR_VOLT_LO: next_st.rdData = st.volt[7:0];
              ADDR_AMP_LO: next_st.rdData = st.amp[7:0];
              default: next_st.rdData = st.temp[7:0];
            endcase
          end
          next_st.shadowAddr = 8'hff;
        end
        default: next_st.rdData = 8'h00;
      endcase
      // Capture the partner byte when the MSB is read
      case (regAddr)
        ADDR_ACC_HI: begin
          next_st.shadow = st.acc[7:0];
          next_st.shadowAddr = ADDR_ACC_LO;
        end
        ADDR_VOLT_HI: begin
          next_st.shadow = st.volt[7:0];
          next_st.shadowAddr = ADDR_VOLT_LO;
        end
        ADDR_AMP_HI: begin
          next_st.shadow = st.amp[7:0];
          next_st.shadowAddr = ADDR_AMP_LO;
        end
        ADDR_TEMP_HI: begin
          next_st.shadow = st.temp[7:0];
          next_st.shadowAddr = ADDR_TEMP_LO;
        end
        default: begin
        end
      endcase
    end
    if (regRdEn && regAddr == ADDR_STATUS) begin
      next_st.status = setBits;
    end else begin
      next_st.status = st.status | setBits;
    end

    // Register writes; result registers ignore writes
    if (regWrEn) begin
      case (regAddr)
        ADDR_CTRL: begin
          next_st.ctrl = regWrData;
          if (regWrData[CTRL_MODE_POS +: 2] == MODE_SINGLE) begin
            next_st.singlePending = 1'b1;
          end
        end
        ADDR_ACC_HI: next_st.acc[15:8] = regWrData;
        ADDR_ACC_LO: next_st.acc[7:0] = regWrData;
        ADDR_CHG_UP_HI: next_st.chgUp[15:8] = regWrData;
        ADDR_CHG_UP_LO: next_st.chgUp[7:0] = regWrData;
        ADDR_CHG_DN_HI: next_st.chgDn[15:8] = regWrData;
        ADDR_CHG_DN_LO: next_st.chgDn[7:0] = regWrData;
        ADDR_VUP_HI: next_st.voltUp[15:8] = regWrData;
        ADDR_VUP_LO: next_st.voltUp[7:0] = regWrData;
        ADDR_VDN_HI: next_st.voltDn[15:8] = regWrData;
        ADDR_VDN_LO: next_st.voltDn[7:0] = regWrData;
        ADDR_AUP_HI: next_st.ampUp[15:8] = regWrData;
        ADDR_AUP_LO: next_st.ampUp[7:0] = regWrData;
        ADDR_ADN_HI: next_st.ampDn[15:8] = regWrData;
        ADDR_ADN_LO: next_st.ampDn[7:0] = regWrData;
        ADDR_TUP: next_st.tempUp = regWrData;
        ADDR_TDN: next_st.tempDn = regWrData;
        default: begin
        end
      endcase
    end

    // Latched alert ignores later pin reconfiguration until acknowledged
    if (alertResponseDone) begin
      next_st.alertLatched = 1'b0;
    end
    if (pinMode == PIN_ALERT && (setBits[6:1] != 6'h00)) begin
      next_st.alertLatched = 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      st <= '0;
      st.status <= RST_STATUS;
      st.ctrl <= RST_CTRL;
      st.acc <= RST_ACC;
      st.chgUp <= RST_UPPER;
      st.chgDn <= RST_LOWER;
      st.voltUp <= RST_UPPER;
      st.voltDn <= RST_LOWER;
      st.ampUp <= RST_UPPER;
      st.ampDn <= RST_LOWER;
      st.tempUp <= RST_TUP;
      st.tempDn <= RST_TDN;
      st.shadowAddr <= 8'hff;
    end else begin
      st <= next_st;
    end
  end

  assign regRdData = st.rdData;
  assign convStart = st.convStart;
  assign analogEnable = ~halt;
  assign alertPinOut = 1'b0;
  assign alertPinOe = st.alertLatched;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (srst);

  AST_STATUS_CLEAR: assert property (regRdEn && regAddr == ADDR_STATUS && setBits == 8'h00
      |=> st.status == 8'h00) else $error("status not cleared by read");
  AST_VOLT_ALERT: assert property (voltDone && (voltIn > st.voltUp || voltIn < st.voltDn)
      |=> st.status[ST_VOLT]) else $error("voltage alert missed");
  AST_AMP_ALERT: assert property (ampDone && (ampIn > st.ampUp || ampIn < st.ampDn)
      |=> st.status[ST_AMP]) else $error("current alert missed");
  AST_TEMP_QUIET: assert property (!tempDone && !(regRdEn && regAddr == ADDR_STATUS)
      && !st.status[ST_TEMP] |=> !st.status[ST_TEMP]) else $error("temp flag without result");
  AST_DROOP_FREEZE: assert property (supplyDroop && !regWrEn && !loadReq
      |=> st.status[ST_DROOP] && $stable(st.acc)) else $error("droop did not freeze");
  AST_SHDN_FREEZE: assert property (st.ctrl[CTRL_SHDN_POS] && !regWrEn && !loadReq
      |=> $stable(st.acc) && !convStart) else $error("shutdown did not freeze");
  AST_ALERT_HOLD: assert property (alertPinOe && !alertResponseDone |=> alertPinOe)
    else $error("alert released early");
  AST_ALERT_RAISE: assert property (pinMode == PIN_ALERT && setBits[6:1] != 6'h00
      |=> alertPinOe) else $error("alert pin not pulled");
  AST_CHG_LOAD: assert property (loadReq && !regWrEn |=> st.acc == ACC_FULL)
    else $error("charge done did not load");
  AST_WRAP: assert property (stepUp && st.acc == 16'hffff && !regWrEn && !loadReq
      |=> st.acc == 16'h0000 && st.status[ST_WRAP]) else $error("wrap not flagged");
  AST_SHADOW: assert property (regRdEn && regAddr == ADDR_VOLT_HI ##1 regRdEn
      && regAddr == ADDR_VOLT_LO |=> regRdData == $past(st.volt[7:0], 2))
    else $error("lsb not consistent with msb");

  COV_SCAN_START: cover property (mode == MODE_SCAN && convStart);
  COV_STATUS_READ: cover property (regRdEn && regAddr == ADDR_STATUS && st.status[ST_CHG_HI]);
  COV_ALERT_ACK: cover property (alertPinOe ##1 alertResponseDone ##1 !alertPinOe);
  COV_CHG_DONE: cover property (loadReq);
endmodule : ggr_register_bank
`default_nettype wire

// ==== logic/ggr_pkg.sv ====
`default_nettype none
package ggr_pkg;
  // Byte register offsets
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_CTRL = 8'h01;
  localparam logic [7:0] ADDR_ACC_HI = 8'h02;
  localparam logic [7:0] ADDR_ACC_LO = 8'h03;
  localparam logic [7:0] ADDR_CHG_UP_HI = 8'h04;
  localparam logic [7:0] ADDR_CHG_UP_LO = 8'h05;
  localparam logic [7:0] ADDR_CHG_DN_HI = 8'h06;
  localparam logic [7:0] ADDR_CHG_DN_LO = 8'h07;
  localparam logic [7:0] ADDR_VOLT_HI = 8'h08;
  localparam logic [7:0] ADDR_VOLT_LO = 8'h09;
  localparam logic [7:0] ADDR_VUP_HI = 8'h0a;
  localparam logic [7:0] ADDR_VUP_LO = 8'h0b;
  localparam logic [7:0] ADDR_VDN_HI = 8'h0c;
  localparam logic [7:0] ADDR_VDN_LO = 8'h0d;
  localparam logic [7:0] ADDR_AMP_HI = 8'h0e;
  localparam logic [7:0] ADDR_AMP_LO = 8'h0f;
  localparam logic [7:0] ADDR_AUP_HI = 8'h10;
  localparam logic [7:0] ADDR_AUP_LO = 8'h11;
  localparam logic [7:0] ADDR_ADN_HI = 8'h12;
  localparam logic [7:0] ADDR_ADN_LO = 8'h13;
  localparam logic [7:0] ADDR_TEMP_HI = 8'h14;
  localparam logic [7:0] ADDR_TEMP_LO = 8'h15;
  localparam logic [7:0] ADDR_TUP = 8'h16;
  localparam logic [7:0] ADDR_TDN = 8'h17;
  // Status bit positions
  localparam int ST_AMP = 6;
  localparam int ST_WRAP = 5;
  localparam int ST_TEMP = 4;
  localparam int ST_CHG_HI = 3;
  localparam int ST_CHG_LO = 2;
  localparam int ST_VOLT = 1;
  localparam int ST_DROOP = 0;
  // Control fields
  localparam int CTRL_MODE_POS = 6;
  localparam int CTRL_PRESC_POS = 3;
  localparam int CTRL_PIN_POS = 1;
  localparam int CTRL_SHDN_POS = 0;
  // Reset values
  localparam logic [7:0] RST_STATUS = 8'h01;
  localparam logic [7:0] RST_CTRL = 8'h3c;
  localparam logic [15:0] RST_ACC = 16'h7fff;
  localparam logic [15:0] RST_UPPER = 16'hffff;
  localparam logic [15:0] RST_LOWER = 16'h0000;
  localparam logic [7:0] RST_TUP = 8'hff;
  localparam logic [7:0] RST_TDN = 8'h00;
  localparam logic [15:0] ACC_FULL = 16'hffff;
  typedef enum logic [1:0] {
    MODE_SLEEP = 2'b00,
    MODE_SINGLE = 2'b01,
    MODE_SCAN = 2'b10,
    MODE_CONT = 2'b11
  } ggr_mode_t;
  typedef enum logic [1:0] {
    PIN_OFF = 2'b00,
    PIN_CHG_DONE = 2'b01,
    PIN_ALERT = 2'b10,
    PIN_BAD = 2'b11
  } ggr_pin_t;
  // Timing
  localparam longint CLK_HZ = 64'd200_000_000;
  localparam longint SCAN_PERIOD_S = 64'd10;
  localparam longint SCAN_CYCLES_DEF = SCAN_PERIOD_S * CLK_HZ;
  // Prescaler top value (factor minus one) per code
  function automatic logic [11:0] ggr_presc_top(input logic [2:0] code);
    case (code)
      3'h0: ggr_presc_top = 12'h000;
      3'h1: ggr_presc_top = 12'h003;
      3'h2: ggr_presc_top = 12'h00f;
      3'h3: ggr_presc_top = 12'h03f;
      3'h4: ggr_presc_top = 12'h0ff;
      3'h5: ggr_presc_top = 12'h3ff;
      default: ggr_presc_top = 12'hfff;
    endcase
  endfunction : ggr_presc_top
endpackage : ggr_pkg
`default_nettype wire

// ==== bench/ggr_host_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module ggr_host_model (
  input wire logic ref_clk,
  output logic [7:0] regAddr,
  output logic regWrEn,
  output logic [7:0] regWrData,
  output logic regRdEn
);
  logic [7:0] expQ[$];
  initial begin
    regAddr = 8'h00;
    regWrEn = 1'b0;
    regWrData = 8'h00;
    regRdEn = 1'b0;
  end
  // Request stays up until the next call, so back-to-back cycles are possible
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    regAddr = a;
    regWrData = d;
    regWrEn = 1'b1;
    regRdEn = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge ref_clk);
    regAddr = a;
    regWrEn = 1'b0;
    regRdEn = 1'b1;
    expQ.push_back(e);
  endtask : rd
  // Released bus shows junk, never the last value
  task automatic idle();
    @(negedge ref_clk);
    regWrEn = 1'b0;
    regRdEn = 1'b0;
    regAddr = ~regAddr;
    regWrData = ~regWrData;
  endtask : idle
endmodule : ggr_host_model
`default_nettype wire

// ==== bench/tb.sv ====
`timescale 1ns/10ps
`default_nettype none
module tb;
  import ggr_pkg::*;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic [7:0] regAddr, regWrData, regRdData, expVal;
  logic regWrEn, regRdEn, rdLag = 1'b0, setDone = 1'b0;
  logic alertResponseDone = 1'b0, chargeTickUp = 1'b0, chargeTickDown = 1'b0;
  logic supplyDroop = 1'b0, convStart, analogEnable, alertPinIn, alertPinOut, alertPinOe;
  logic voltDone = 1'b0, ampDone = 1'b0, tempDone = 1'b0;
  logic [15:0] voltIn = 16'h0000, ampIn = 16'h0000, tempIn = 16'h0000;
  logic [15:0] voltVal, ampVal, tempVal;
  int numErrors = 0, compares = 0, cycles = 0, convStarts = 0;
  logic chgDoneLow = 1'b0;
  logic [7:0] rstTab [0:23] = '{8'h01, 8'h3c, 8'h7f, 8'hff, 8'hff, 8'hff, 8'h00, 8'h00,
    8'h00, 8'h00, 8'hff, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'hff, 8'h00, 8'h00,
    8'h00, 8'h00, 8'hff, 8'h00};
  always #2.5 ref_clk = ~ref_clk;
  // Open-drain pin with pull-up
  // Charger side pulls the shared pin low for charge done
  assign alertPinIn = (alertPinOe ? alertPinOut : 1'b1) & ~chgDoneLow;
  ggr_host_model hostModel (.ref_clk(ref_clk), .regAddr(regAddr), .regWrEn(regWrEn),
    .regWrData(regWrData), .regRdEn(regRdEn));
  ggr_register_bank #(.SCAN_CYCLES(31'd50)) DUT (.ref_clk(ref_clk), .srst(srst),
    .regAddr(regAddr), .regWrEn(regWrEn), .regWrData(regWrData), .regRdEn(regRdEn),
    .regRdData(regRdData), .alertResponseDone(alertResponseDone),
    .chargeTickUp(chargeTickUp), .chargeTickDown(chargeTickDown),
    .supplyDroop(supplyDroop), .convStart(convStart), .voltDone(voltDone), .voltIn(voltIn),
    .ampDone(ampDone), .ampIn(ampIn), .tempDone(tempDone), .tempIn(tempIn),
    .analogEnable(analogEnable), .alertPinIn(alertPinIn), .alertPinOut(alertPinOut),
    .alertPinOe(alertPinOe));
  task automatic stop_test();
    if (numErrors == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : stop_test
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      numErrors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // Read data lands one cycle after the read edge
  always @(posedge ref_clk) rdLag <= regRdEn & ~srst;
  always @(negedge ref_clk) begin
    if (rdLag) begin
      expVal = hostModel.expQ.pop_front();
      chk("read data", expVal, regRdData);
    end
  end
  always @(negedge ref_clk) begin
    if (convStart) begin
      convStarts++;
    end
  end
  // Converter front end: answers each start with one result set
  always @(negedge ref_clk) begin
    if (convStart) begin
      repeat (2) @(negedge ref_clk);
      voltIn = voltVal;
      voltDone = 1'b1;
      @(negedge ref_clk);
      voltDone = 1'b0;
      ampIn = ampVal;
      ampDone = 1'b1;
      @(negedge ref_clk);
      ampDone = 1'b0;
      tempIn = tempVal;
      tempDone = 1'b1;
      @(negedge ref_clk);
      tempDone = 1'b0;
      voltIn = ~voltIn;
      ampIn = ~ampIn;
      tempIn = ~tempIn;
      setDone = 1'b1;
    end
  end
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 60000) begin
      numErrors++;
      stop_test();
    end
  end
  task automatic convert(input logic [15:0] v, input logic [15:0] t);
    voltVal = v;
    tempVal = t;
    ampVal = 16'($urandom);
    setDone = 1'b0;
    hostModel.wr(8'h01, 8'h44);
    hostModel.idle();
    for (int i = 0; i < 30 && !setDone; i++) @(negedge ref_clk);
    chk("conversion done", 8'h01, {7'h00, setDone});
  endtask : convert
  task automatic tick(input logic up, input int n);
    hostModel.idle();
    for (int i = 0; i < n; i++) begin
      @(negedge ref_clk);
      chargeTickUp = up;
      chargeTickDown = ~up;
      @(negedge ref_clk);
      chargeTickUp = 1'b0;
      chargeTickDown = 1'b0;
    end
  endtask : tick
  // Mode runs 90 cycles, then sleep; a started set is let finish
  task automatic runMode(input logic [7:0] ctl, input logic [7:0] exp);
    convStarts = 0;
    hostModel.wr(8'h01, ctl);
    hostModel.idle();
    repeat (88) @(negedge ref_clk);
    hostModel.wr(8'h01, 8'h00);
    hostModel.idle();
    repeat (10) @(negedge ref_clk);
    chk("conversion starts", exp, 8'(convStarts));
  endtask : runMode
  initial begin
    int fac;
    void'($urandom(32'h08df));
    repeat (5) @(negedge ref_clk);
    srst = 1'b0;
    for (int a = 0; a < 24; a++) hostModel.rd(8'(a), rstTab[a]);
    hostModel.rd(8'h18, 8'h00);
    hostModel.rd(8'h00, 8'h00);
    hostModel.wr(8'h08, 8'ha5);
    hostModel.wr(8'h0a, 8'h80);
    hostModel.wr(8'h0b, 8'h00);
    hostModel.wr(8'h17, 8'h40);
    hostModel.rd(8'h08, 8'h00);
    hostModel.rd(8'h0a, 8'h80);
    hostModel.rd(8'h17, 8'h40);
    convert(16'h8000 + 16'($urandom_range(32'h7fff, 32'h1)), 16'h3f00);
    hostModel.rd(8'h08, voltVal[15:8]);
    hostModel.rd(8'h09, voltVal[7:0]);
    hostModel.rd(8'h0e, ampVal[15:8]);
    hostModel.rd(8'h0f, ampVal[7:0]);
    hostModel.rd(8'h00, 8'h12);
    hostModel.rd(8'h00, 8'h00);
    hostModel.wr(8'h01, 8'h00);
    hostModel.idle();
    chk("alert held", 8'h01, {7'h00, alertPinOe});
    chk("alert pin level", 8'h00, {7'h00, alertPinIn});
    @(negedge ref_clk) alertResponseDone = 1'b1;
    @(negedge ref_clk) alertResponseDone = 1'b0;
    chk("alert released", 8'h00, {7'h00, alertPinOe});
    // Results equal to the limits must not flag
    convert(16'h8000, 16'h4000);
    hostModel.rd(8'h00, 8'h00);
    hostModel.wr(8'h01, 8'h04);
    hostModel.wr(8'h02, 8'hff);
    hostModel.wr(8'h03, 8'hff);
    tick(1'b1, 1);
    tick(1'b0, 1);
    hostModel.rd(8'h00, 8'h20);
    hostModel.rd(8'h02, 8'hff);
    hostModel.rd(8'h03, 8'hff);
    hostModel.wr(8'h04, 8'h00);
    hostModel.wr(8'h05, 8'h10);
    for (int c = 0; c < 8; c++) begin
      fac = (c > 5) ? 4096 : (1 << (2 * c));
      hostModel.wr(8'h01, {2'b00, 3'(c), 3'b100});
      hostModel.wr(8'h02, 8'h10);
      hostModel.wr(8'h03, 8'h00);
      tick(1'b1, fac - 1);
      hostModel.rd(8'h03, 8'h00);
      tick(1'b1, 1);
      hostModel.rd(8'h02, 8'h10);
      hostModel.rd(8'h03, 8'h01);
    end
    hostModel.rd(8'h00, 8'h08);
    hostModel.wr(8'h01, 8'h05);
    hostModel.wr(8'h02, 8'h01);
    hostModel.wr(8'h03, 8'h00);
    tick(1'b1, 1);
    supplyDroop = 1'b1;
    hostModel.wr(8'h01, 8'h04);
    chk("analog enable", 8'h00, {7'h00, analogEnable});
    tick(1'b1, 1);
    supplyDroop = 1'b0;
    hostModel.rd(8'h00, 8'h01);
    hostModel.rd(8'h03, 8'h00);
    tick(1'b1, 1);
    hostModel.rd(8'h00, 8'h08);
    hostModel.rd(8'h02, 8'h01);
    hostModel.rd(8'h03, 8'h01);
    hostModel.idle();
    @(negedge ref_clk) alertResponseDone = 1'b1;
    @(negedge ref_clk) alertResponseDone = 1'b0;
    hostModel.wr(8'h01, 8'h02);
    hostModel.idle();
    chgDoneLow = 1'b1;
    @(negedge ref_clk) chgDoneLow = 1'b0;
    hostModel.rd(8'h02, 8'hff);
    hostModel.rd(8'h03, 8'hff);
    runMode(8'h80, 8'h02);
    runMode(8'hc0, 8'h0f);
    stop_test();
  end
endmodule : tb
`default_nettype wire
